// File: bss_boot_select.sv
// boot source select: option byte mirror, boot decision and avalon slave
// How it works
// R1 - boot starts at flash base or rom base according to chosen source
// R2 - option byte from flash mirrored into a read-only register
// R3 - pin decides only with nmi enabled and pin choice bit zero
// R4 - pin low in pin mode boots from rom
// R5 - pin high in pin mode boots from flash
// R6 - pin choice bit one ignores pin, source field decides
// R7 - field bits 7:6: 00 flash, 01 reserved, 10 and 11 rom
// R8 - erased option byte, all ones, boots from rom
// R9 - selection redone after every power-on reset
// R10 - software may force rom boot with chosen config after non-por reset
// R11 - reset may exit straight into very low power run
// R12 - software leaves very low power run before flash writes
// R13 - bit 5 clear gives slow init timed by boot divider
// R14 - bit 5 set gives fast init on every reset kind
// R15 - bit 3 enables or disables dedicated reset pin
// R16 - pin choice bit sits at bit 1
// R17 - bit 2 zero blocks nonmaskable interrupts
// R18 - low power boot field sets divider 8,4,2,1; codes 00,01 enter very_low_power_run
// R19 - decision latched once at reset release and held
module bss_boot_select
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_por,
    input  wire logic [7:0]  i_flash_option_byte,
    input  wire logic        i_boot_config_pin,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic [31:0]      o_boot_addr,
    output logic             o_boot_from_rom,
    output logic             o_boot_ready,
    output logic [2:0]       o_core_clock_divider,
    output logic             o_very_low_power_run,
    output logic             o_fast_init,
    output logic             o_reset_pin_enable,
    output logic             o_nmi_enable
);
    // ----------------------------------------
    // decision function
    // ----------------------------------------
    function automatic logic rom_choice(input logic [7:0] opt, input logic pin);
        logic r;
        r = 1'b0;
        if (opt[bss_pkg::PINOPT_BIT]) // R6 R16
            r = opt[bss_pkg::SRC_MSB]; // R7 R8
        else if (opt[bss_pkg::NMIDIS_BIT]) // R3
            r = ~pin; // R4 R5
        else
            r = 1'b0;
        return r;
    endfunction

    function automatic logic [2:0] div_code(input logic [1:0] lpb);
        logic [2:0] d;
        d = bss_pkg::DIV_BY1;
        case (lpb) // R18
            2'h0: d = bss_pkg::DIV_BY8;
            2'h1: d = bss_pkg::DIV_BY4;
            2'h2: d = bss_pkg::DIV_BY2;
            default: d = bss_pkg::DIV_BY1;
        endcase
        return d;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    bss_pkg::bss_state_e state_reg, state_next;
    logic [7:0]  opt_reg, opt_next;
    logic        rom_reg, rom_next;
    logic [9:0]  cnt_reg, cnt_next;
    logic        force_reg, force_next;
    logic [1:0]  fcfg_reg, fcfg_next;
    logic        ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  lpb;
    logic        req;
    logic [7:0]  eff_opt;

    assign lpb = {opt_reg[bss_pkg::LPB_HI_BIT], opt_reg[bss_pkg::LPB_LO_BIT]};
    assign req = i_avs_read | i_avs_write;

    // forced rom boot overrides pin/field config on a non-por reset
    always_comb
    begin
        eff_opt = i_flash_option_byte;
        if (force_reg) // R10
        begin
            eff_opt[bss_pkg::PINOPT_BIT] = fcfg_reg[0];
            eff_opt[bss_pkg::NMIDIS_BIT] = fcfg_reg[1];
        end
    end

    always_comb
    begin
        state_next    = state_reg;
        opt_next      = opt_reg;
        rom_next      = rom_reg;
        cnt_next      = cnt_reg;
        case (state_reg)
            bss_pkg::ST_LOAD:
            begin
                opt_next = i_flash_option_byte; // R2
                if (force_reg)
                    rom_next = 1'b1; // R10
                else
                    rom_next = rom_choice(eff_opt, i_boot_config_pin); // R9
                if (i_flash_option_byte[bss_pkg::FAST_BIT]) // R14
                    cnt_next = 10'(bss_pkg::INIT_FAST_CYC);
                else // R13
                    cnt_next = 10'(bss_pkg::INIT_SLOW_CYC)
                             << (2'h3 - {i_flash_option_byte[bss_pkg::LPB_HI_BIT],
                                        i_flash_option_byte[bss_pkg::LPB_LO_BIT]});
                state_next = bss_pkg::ST_INIT;
            end
            bss_pkg::ST_INIT:
            begin
                if (cnt_reg <= 10'h001)
                    state_next = bss_pkg::ST_RUN;
                else
                    cnt_next = cnt_reg - 10'h001;
            end
            default:
            begin
                state_next = bss_pkg::ST_RUN; // R19
            end
        endcase
    end

    // software force control, survives only non-por resets via i_por
    always_comb
    begin
        force_next = force_reg;
        fcfg_next  = fcfg_reg;
        ack_next   = 1'b0;
        rdata_next = rdata_reg;
        if (req && !ack_reg)
        begin
            ack_next = 1'b1;
            if (i_avs_read)
            begin
                if (i_avs_address == bss_pkg::OFS_OPTIONS)
                    rdata_next = {24'h0, opt_reg}; // R2
                else if (i_avs_address == bss_pkg::OFS_STATUS)
                    rdata_next = {28'h0, state_reg == bss_pkg::ST_RUN, o_very_low_power_run,
                                  o_fast_init, rom_reg};
                else if (i_avs_address == bss_pkg::OFS_FORCE_CTRL)
                    rdata_next = {29'h0, fcfg_reg, force_reg};
                else if (i_avs_address == bss_pkg::OFS_BOOT_ADDR)
                    rdata_next = o_boot_addr;
                else
                    rdata_next = 32'h0;
            end
            else if (i_avs_address == bss_pkg::OFS_FORCE_CTRL && i_avs_byteenable[0])
            begin
                force_next = i_avs_writedata[0]; // R10
                fcfg_next  = i_avs_writedata[2:1];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg    <= bss_pkg::ST_LOAD;
            opt_reg      <= bss_pkg::OPTION_ERASED;
            rom_reg      <= 1'b1;
            cnt_reg      <= 10'h000;
            ack_reg      <= 1'b0;
            rdata_reg    <= 32'h0;
        end
        else
        begin
            state_reg    <= state_next;
            opt_reg      <= opt_next;
            rom_reg      <= rom_next;
            cnt_reg      <= cnt_next;
            ack_reg      <= ack_next;
            rdata_reg    <= rdata_next;
        end
    end

    // force state is cleared by power-on reset or a software write of zero, never by i_rst
    always_ff @(posedge i_clk or posedge i_por)
    begin
        if (i_por)
        begin
            force_reg <= 1'b0;
            fcfg_reg  <= 2'h0;
        end
        else
        begin
            force_reg <= force_next;
            fcfg_reg  <= fcfg_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_boot_from_rom      = rom_reg;
    assign o_boot_addr          = rom_reg ? bss_pkg::ROM_BASE_ADDR : bss_pkg::FLASH_BASE_ADDR; // R1
    assign o_boot_ready         = (state_reg == bss_pkg::ST_RUN);
    assign o_core_clock_divider = div_code(lpb); // R18
    assign o_very_low_power_run = ~lpb[1]; // R11 R18
    assign o_fast_init          = opt_reg[bss_pkg::FAST_BIT]; // R14
    assign o_reset_pin_enable   = opt_reg[bss_pkg::RSTPIN_BIT]; // R15
    assign o_nmi_enable         = opt_reg[bss_pkg::NMIDIS_BIT]; // R17
    assign o_avs_waitrequest    = req & ~ack_reg;
    assign o_avs_readdata       = rdata_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_addr_match;
        @(posedge i_clk) disable iff (i_rst)
        o_boot_addr == (o_boot_from_rom ? bss_pkg::ROM_BASE_ADDR : bss_pkg::FLASH_BASE_ADDR);
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("boot address mismatch"); // R1

    property p_mirror;
        @(posedge i_clk) disable iff (i_rst)
        state_reg == bss_pkg::ST_LOAD |=> opt_reg == $past(i_flash_option_byte);
    endproperty
    a_mirror: assert property (p_mirror) else $error("option byte not mirrored"); // R2

    property p_pin_low;
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == bss_pkg::ST_LOAD && !force_reg && !i_flash_option_byte[1]
         && i_flash_option_byte[2] && !i_boot_config_pin) |=> o_boot_from_rom;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin low did not pick rom"); // R4

    property p_pin_high;
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == bss_pkg::ST_LOAD && !force_reg && !i_flash_option_byte[1]
         && i_flash_option_byte[2] && i_boot_config_pin) |=> !o_boot_from_rom;
    endproperty
    a_pin_high: assert property (p_pin_high) else $error("pin high did not pick flash"); // R5

    property p_field;
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == bss_pkg::ST_LOAD && !force_reg && i_flash_option_byte[1])
        |=> o_boot_from_rom == $past(i_flash_option_byte[7]);
    endproperty
    a_field: assert property (p_field) else $error("field decode wrong"); // R7

    property p_hold;
        @(posedge i_clk) disable iff (i_rst)
        state_reg != bss_pkg::ST_LOAD |=> $stable(o_boot_from_rom);
    endproperty
    a_hold: assert property (p_hold) else $error("boot choice changed"); // R19

    property p_very_low_power_run;
        @(posedge i_clk) disable iff (i_rst)
        o_very_low_power_run == (o_core_clock_divider == bss_pkg::DIV_BY8
                                 || o_core_clock_divider == bss_pkg::DIV_BY4);
    endproperty
    a_very_low_power_run: assert property (p_very_low_power_run) else $error("very_low_power_run and divider disagree"); // R18

    sequence s_fast_load;
        state_reg == bss_pkg::ST_LOAD && i_flash_option_byte[5];
    endsequence
    property p_fast;
        @(posedge i_clk) disable iff (i_rst)
        s_fast_load |=> ##[0:12] o_boot_ready;
    endproperty
    a_fast: assert property (p_fast) else $error("fast init too slow"); // R14

    sequence s_forced_load;
        state_reg == bss_pkg::ST_LOAD && force_reg;
    endsequence
    property p_force;
        @(posedge i_clk) disable iff (i_rst)
        s_forced_load |=> o_boot_from_rom;
    endproperty
    a_force: assert property (p_force) else $error("forced rom boot ignored"); // R10

    property p_erased;
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == bss_pkg::ST_LOAD && !force_reg
         && i_flash_option_byte == bss_pkg::OPTION_ERASED) |=> o_boot_from_rom;
    endproperty
    a_erased: assert property (p_erased) else $error("erased option byte did not pick rom"); // R8

    sequence s_slow_load;
        state_reg == bss_pkg::ST_LOAD && !i_flash_option_byte[bss_pkg::FAST_BIT];
    endsequence
    property p_slow;
        @(posedge i_clk) disable iff (i_rst)
        s_slow_load |=> !o_boot_ready [*8];
    endproperty
    a_slow: assert property (p_slow) else $error("slow init finished too soon"); // R13
endmodule

// File: bss_pkg.sv
// boot source select constants and register map
package bss_pkg;
    // ----------------------------------------
    // addresses
    // ----------------------------------------
    localparam logic [31:0] FLASH_BASE_ADDR   = 32'h0000_0000;
    localparam logic [31:0] ROM_BASE_ADDR     = 32'h1C00_0000;
    localparam logic [31:0] OPTION_NVM_ADDR   = 32'h0000_040D;
    localparam logic [31:0] OPTIONS_REG_ADDR  = 32'h4002_0003;
    // own registers, word aligned in the block window
    localparam logic [3:0]  OFS_OPTIONS       = 4'h0;
    localparam logic [3:0]  OFS_STATUS        = 4'h4;
    localparam logic [3:0]  OFS_FORCE_CTRL    = 4'h8;
    localparam logic [3:0]  OFS_BOOT_ADDR     = 4'hC;
    // ----------------------------------------
    // option byte fields
    // ----------------------------------------
    localparam int SRC_MSB      = 7;
    localparam int SRC_LSB      = 6;
    localparam int FAST_BIT     = 5;
    localparam int LPB_HI_BIT   = 4;
    localparam int RSTPIN_BIT   = 3;
    localparam int NMIDIS_BIT   = 2;
    localparam int PINOPT_BIT   = 1;
    localparam int LPB_LO_BIT   = 0;
    localparam logic [7:0] OPTION_ERASED = 8'hFF;
    localparam logic [1:0] SRC_FLASH     = 2'h0;
    localparam logic [1:0] SRC_RSVD      = 2'h1;
    // ----------------------------------------
    // divider codes and timing
    // ----------------------------------------
    localparam logic [2:0] DIV_BY8 = 3'h7;
    localparam logic [2:0] DIV_BY4 = 3'h3;
    localparam logic [2:0] DIV_BY2 = 3'h1;
    localparam logic [2:0] DIV_BY1 = 3'h0;
    localparam int CLK_MHZ          = 100;
    localparam int INIT_FAST_NS     = 100;
    localparam int INIT_FAST_CYC    = (INIT_FAST_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_SLOW_CYC    = INIT_FAST_CYC * 4;
    localparam logic [1:0] LOAD_DELAY = 2'h2;
    typedef enum logic [1:0]
    {
        ST_LOAD = 2'b00,
        ST_INIT = 2'b01,
        ST_RUN  = 2'b10
    } bss_state_e;
endpackage

// File: bss_pin_model.sv
// boot config pin model: shared pin with pull-up when released
module bss_pin_model
(
    input  wire logic i_clk,
    input  wire logic i_drive_low,
    output logic      o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_reg;
    // released pin floats to its pull-up level, never to the last value
    always_ff @(posedge i_clk)
    begin
        pin_reg <= i_drive_low ? 1'b0 : 1'b1;
    end
    assign o_pin = pin_reg;
endmodule

// File: bss_boot_select_test.sv
// self-checking bench for boot source select
module bss_boot_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, por, drv_low, pin, avs_rd, avs_wr, avs_wait, rom, ready, low_pwr_run, fast, rstpin, nmi;
    logic [7:0]  opt;
    logic [3:0]  avs_a;
    logic [31:0] avs_wd, avs_q, boot_addr, d;
    logic [2:0]  div;
    int          fails, cmp_count, cyc;
    logic [2:0]  div_tab [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
    // option byte, pin level, expected rom choice
    logic [9:0]  cases [9] = '{{8'hFF, 2'b11}, {8'h3D, 2'b01}, {8'h3D, 2'b10}, {8'h3E, 2'b00}, {8'hBE, 2'b11},
                               {8'h7E, 2'b00}, {8'h39, 2'b00}, {8'h0E, 2'b10}, {8'hC7, 2'b11}};

    bss_pin_model i_bss_pin_model (.i_clk(clk), .i_drive_low(drv_low), .o_pin(pin));

    bss_boot_select i_bss_boot_select (
        .i_clk(clk), .i_rst(rst), .i_por(por), .i_flash_option_byte(opt), .i_boot_config_pin(pin),
        .i_avs_address(avs_a), .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(avs_q), .o_avs_waitrequest(avs_wait),
        .o_boot_addr(boot_addr), .o_boot_from_rom(rom), .o_boot_ready(ready), .o_core_clock_divider(div),
        .o_very_low_power_run(low_pwr_run), .o_fast_init(fast), .o_reset_pin_enable(rstpin), .o_nmi_enable(nmi));

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            summarize();
        end
    end

    task automatic summarize();
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_rd <= ~w;
        avs_wr <= w;
        avs_a <= a;
        avs_wd <= wd;
        @(posedge clk);
        while (avs_wait !== 1'b0)
        begin
            @(posedge clk);
            n++;
        end
        d = avs_q;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
        chk(n, 1, "bus answer");
    endtask

    // reset with given option byte and pin, then judge the boot outcome
    task automatic boot(input logic [7:0] o, input logic p, input logic pwr, input logic erom);
        int n;
        logic [31:0] ea;
        n = 0;
        ea = erom ? 32'h1C00_0000 : 32'h0000_0000;
        @(posedge clk);
        opt <= o;
        drv_low <= ~p;
        rst <= 1'b1;
        por <= pwr;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk);
        while (ready !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        chk(rom, erom, "rom select");
        chk(boot_addr, ea, "boot address");
        chk(n < 20, o[5], "init speed");
        chk(div, div_tab[{o[4], o[0]}], "divider");
        chk(low_pwr_run, !o[4], "low power run");
        chk(fast, o[5], "fast init");
        bus(1'b0, 4'h4, 32'h0);
        chk(d, {28'h0, 1'b1, ~o[4], o[5], erom}, "status");
        bus(1'b0, 4'hC, 32'h0);
        chk(d, ea, "boot address reg");
        if (pwr)
        begin
            chk(rstpin, o[3], "reset pin");
            chk(nmi, o[2], "nmi enable");
            bus(1'b0, 4'h0, 32'h0);
            chk(d, {24'h0, o}, "option mirror");
        end
        opt <= ~o;
        drv_low <= p;
        repeat (4) @(posedge clk);
        chk(rom, erom, "latched choice");
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        por = 1'b1;
        opt = 8'hFF;
        drv_low = 1'b0;
        avs_a = 4'h0;
        avs_rd = 1'b0;
        avs_wr = 1'b0;
        avs_wd = 32'h0;
        fails = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        for (int k = 0; k < 9; k++)
            boot(cases[k][9:2], cases[k][1], 1'b1, cases[k][0]);
        bus(1'b1, 4'h0, 32'h0000_0000);
        bus(1'b0, 4'h0, 32'h0);
        chk(d, 32'h0000_00C7, "read only option");
        bus(1'b0, 4'h2, 32'h0);
        chk(d, 32'h0, "unmapped read");
        // writes go only to force control, never to flash
        bus(1'b1, 4'h8, 32'h0000_0007);
        boot(8'h3E, 1'b1, 1'b0, 1'b1);
        bus(1'b1, 4'h8, 32'h0000_0007);
        boot(8'h3E, 1'b1, 1'b1, 1'b0);
        summarize();
    end
endmodule
